// ===== hdl/sgd_defs.vh
// Summary of operation
// - Entry: address word, then flags and count
// - Entry bit 16 flags page interrupt
// - Main address and count registers are read-only
// - Main current address loads from next, ends one word past the last used
// - Main current count/control loads from next
// - List engine fills main next registers; 8-byte stride
// - List next copies to current when valid, idle
// - Next-empty enable lets start acceptance raise bit 12
// - List-done bit reads zero while list runs
// - Start write locks next address, length, direction, burst until copied
// - Bit 28 enables page-done interrupt bit 18
// - List-done enable lets done raise bit 12
// - Abort stops, cancels, clears bits 29, 30
// - Direction one reads host memory, zero writes
// - Burst bit selects immediate or coalesced writes
// - Status bits show main idle and next empty
// - Page interrupt sets on flagged page, clears via 28
// - Bits 17, 16 show current and next page flags
// - Low sixteen bits hold next list byte length
// - Bit 12 gathers enabled DMA interrupts, bit 15 gates
// - Remote interrupt needs bits 14 and 15
`ifndef SGD_DEFS_VH
`define SGD_DEFS_VH

// Register offsets, channel 0; channels repeat at the stride
`define SGD_OFF_MCA     8'h00
`define SGD_OFF_MNA     8'h04
`define SGD_OFF_MCC     8'h08
`define SGD_OFF_MNC     8'h0c
`define SGD_OFF_LCA     8'h10
`define SGD_OFF_LNA     8'h14
`define SGD_OFF_LCC     8'h18
`define SGD_OFF_LNC     8'h1c
`define SGD_OFF_CFG     8'hc4
`define SGD_OFF_STAT    8'hc8
`define SGD_CHAN_STRIDE 8'h20

// List next count/control bit positions
`define SGD_B_EN_EMPTY  31
`define SGD_B_DONE      30
`define SGD_B_START     29
`define SGD_B_EN_PAGE   28
`define SGD_B_EN_LIST   27
`define SGD_B_ABORT     26
`define SGD_B_DIR       25
`define SGD_B_BURST     24
`define SGD_B_MIDLE     23
`define SGD_B_NEMPTY    22
`define SGD_B_PGIRQ     18
`define SGD_B_CURPG     17
`define SGD_B_NXTPG     16
// Page-interrupt flag inside the second word of a list entry
`define SGD_B_ENTRY_PG  16
// Configuration and status bit positions
`define SGD_B_GLB_EN    15
`define SGD_B_RMT_EN    14
`define SGD_B_BUSIRQ    15
`define SGD_B_RMTIRQ    13
`define SGD_B_DMAIRQ    12

// Steps and constants
`define SGD_ENTRY_BYTES 16'h0008
`define SGD_ENTRY_STEP  32'h0000_0008
`define SGD_WORD_STEP   32'h0000_0004
`define SGD_WORD_DEC    16'h0001
`define SGD_CTRL_WORD   32'h0000_0004
`define SGD_ZERO32      32'h0000_0000
`define SGD_ZERO16      16'h0000

`endif

// ===== hdl/sgd_channel.v
`timescale 1ns/100ps
`default_nettype none
`include "sgd_defs.vh"

module sgd_channel #(
  parameter [7:0] CHAN_BASE = 8'h00
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_b,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata_q,
  output reg         reg_ack_q,
  // Host memory master
  output reg         mem_req_q,
  output reg         mem_we_q,
  output reg  [31:0] mem_addr_q,
  output reg  [31:0] mem_wdata_q,
  output reg         mem_burst_q,
  input  wire [31:0] mem_rdata,
  input  wire        mem_ack,
  // Board stream towards the board
  output reg  [31:0] brd_tx_data_q,
  output reg         brd_tx_valid_q,
  input  wire        brd_tx_ready,
  // Board stream from the board
  input  wire [31:0] brd_rx_data,
  input  wire        brd_rx_valid,
  output reg         brd_rx_ready_q,
  // Remote logic and bus interrupt
  input  wire        remote_irq,
  output reg         bus_irq_q
);

  // Sequencer states
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_LF0  = 3'd1;
  localparam [2:0] ST_LF1  = 3'd2;
  localparam [2:0] ST_MRD  = 3'd3;
  localparam [2:0] ST_TX   = 3'd4;
  localparam [2:0] ST_RX   = 3'd5;
  localparam [2:0] ST_MWR  = 3'd6;

  // Register state
  reg [31:0] main_cur_addr_q;
  reg [31:0] main_nxt_addr_q;
  reg [31:0] main_cur_cnt_q;
  reg [31:0] main_nxt_cnt_q;
  reg        main_act_q;
  reg        main_nfull_q;
  // List engine
  reg [31:0] list_cur_addr_q;
  reg [31:0] list_nxt_addr_q;
  reg [15:0] list_cur_len_q;
  reg [15:0] list_nxt_len_q;
  reg        list_act_q;
  reg        list_nvalid_q;
  reg        start_rd_q;
  reg        list_done_q;
  // Software enables and mode bits
  reg        en_empty_q;
  reg        en_page_q;
  reg        en_list_q;
  reg        dir_rd_q;
  reg        burst_q;
  reg        page_irq_q;
  reg        glb_en_q;
  reg        rmt_en_q;
  reg        rmt_irq_q;
  // Shared sequencer
  reg [2:0]  state_q;
  reg [31:0] entry_addr_q;

  // Decode of the register port
  wire [7:0] loc_addr = reg_addr - CHAN_BASE;
  wire       wr_lna   = reg_wr && (loc_addr == `SGD_OFF_LNA);
  wire       wr_lnc   = reg_wr && (loc_addr == `SGD_OFF_LNC);
  wire       wr_cfg   = reg_wr && (reg_addr == `SGD_OFF_CFG);
  wire       abort    = wr_lnc && reg_wdata[`SGD_B_ABORT];
  wire       start    = wr_lnc && reg_wdata[`SGD_B_START] && !list_nvalid_q;
  // List copy happens only when the next pair is valid and no list runs
  wire       list_copy = list_nvalid_q && !list_act_q && !abort;

  // Interrupt sources are levels; the DMA ones hold the bus line until cleared, the remote one follows its line
  wire dma_irq = (en_empty_q && start_rd_q)
               | (en_list_q && list_done_q)
               | page_irq_q;
  wire bus_irq_d = glb_en_q && (dma_irq || (rmt_en_q && rmt_irq_q));

  // Address and count after one word moves, shared by both directions
  wire [31:0] main_addr_inc = main_cur_addr_q + `SGD_WORD_STEP;
  wire [15:0] main_cnt_dec  = main_cur_cnt_q[15:0] - `SGD_WORD_DEC;

  // Readback views, each field at its named bit so the map lives in the header
  reg [31:0] lnc_view;
  reg [31:0] cfg_view;
  reg [31:0] stat_view;
  always @* begin
    lnc_view                  = {`SGD_ZERO16, list_nxt_len_q};
    lnc_view[`SGD_B_EN_EMPTY] = en_empty_q;
    lnc_view[`SGD_B_DONE]     = list_done_q;
    lnc_view[`SGD_B_START]    = start_rd_q;
    lnc_view[`SGD_B_EN_PAGE]  = en_page_q;
    lnc_view[`SGD_B_EN_LIST]  = en_list_q;
    // Abort is a strobe, so it never reads back
    lnc_view[`SGD_B_ABORT]    = 1'b0;
    lnc_view[`SGD_B_DIR]      = dir_rd_q;
    lnc_view[`SGD_B_BURST]    = burst_q;
    lnc_view[`SGD_B_MIDLE]    = !main_act_q;
    lnc_view[`SGD_B_NEMPTY]   = !main_nfull_q;
    lnc_view[`SGD_B_PGIRQ]    = page_irq_q;
    lnc_view[`SGD_B_CURPG]    = main_cur_cnt_q[`SGD_B_ENTRY_PG];
    lnc_view[`SGD_B_NXTPG]    = main_nxt_cnt_q[`SGD_B_ENTRY_PG];
    cfg_view                  = `SGD_ZERO32;
    cfg_view[`SGD_B_GLB_EN]   = glb_en_q;
    cfg_view[`SGD_B_RMT_EN]   = rmt_en_q;
    stat_view                 = `SGD_ZERO32;
    stat_view[`SGD_B_BUSIRQ]  = bus_irq_q;
    stat_view[`SGD_B_RMTIRQ]  = rmt_irq_q;
    stat_view[`SGD_B_DMAIRQ]  = dma_irq;
  end

  // Read multiplexer; unmapped offsets read zero
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = `SGD_ZERO32;
    if (reg_addr == `SGD_OFF_CFG) begin
      rdata_d = cfg_view;
    end else if (reg_addr == `SGD_OFF_STAT) begin
      rdata_d = stat_view;
    end else begin
      case (loc_addr)
        `SGD_OFF_MCA: rdata_d = main_cur_addr_q;
        `SGD_OFF_MNA: rdata_d = main_nxt_addr_q;
        `SGD_OFF_MCC: rdata_d = main_cur_cnt_q;
        `SGD_OFF_MNC: rdata_d = main_nxt_cnt_q;
        `SGD_OFF_LCA: rdata_d = list_cur_addr_q;
        `SGD_OFF_LNA: rdata_d = list_nxt_addr_q;
        `SGD_OFF_LCC: rdata_d = {lnc_view[31:16], list_cur_len_q};
        `SGD_OFF_LNC: rdata_d = lnc_view;
        default:      rdata_d = `SGD_ZERO32;
      endcase
    end
  end

  // Register port answers one cycle after a read or write strobe
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= `SGD_ZERO32;
      reg_ack_q   <= 1'b0;
    end else begin
      reg_ack_q <= reg_wr || reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

  // Software control bits, interrupts and the list next pair
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_empty_q      <= 1'b0;
      en_page_q       <= 1'b0;
      en_list_q       <= 1'b0;
      dir_rd_q        <= 1'b0;
      burst_q         <= 1'b0;
      glb_en_q        <= 1'b0;
      rmt_en_q        <= 1'b0;
      rmt_irq_q       <= 1'b0;
      bus_irq_q       <= 1'b0;
      list_nxt_addr_q <= `SGD_ZERO32;
      list_nxt_len_q  <= `SGD_ZERO16;
      list_nvalid_q   <= 1'b0;
      start_rd_q      <= 1'b1;
    end else begin
      // Remote line is sampled once; the bus line lags its sources a cycle
      rmt_irq_q <= remote_irq;
      bus_irq_q <= bus_irq_d;
      // Enables stay writable so a running page interrupt can be cleared
      if (wr_lnc) begin
        en_empty_q <= reg_wdata[`SGD_B_EN_EMPTY];
        en_page_q  <= reg_wdata[`SGD_B_EN_PAGE];
        en_list_q  <= reg_wdata[`SGD_B_EN_LIST];
      end
      // Locked fields change only while the next pair is free
      if (wr_lnc && !list_nvalid_q) begin
        dir_rd_q       <= reg_wdata[`SGD_B_DIR];
        burst_q        <= reg_wdata[`SGD_B_BURST];
        list_nxt_len_q <= reg_wdata[15:0];
      end
      if (wr_lna && !list_nvalid_q) begin
        list_nxt_addr_q <= reg_wdata;
      end
      if (wr_cfg) begin
        glb_en_q <= reg_wdata[`SGD_B_GLB_EN];
        rmt_en_q <= reg_wdata[`SGD_B_RMT_EN];
      end
      // Start locks, copy unlocks, abort clears the start bit
      if (abort) begin
        list_nvalid_q <= 1'b0;
        start_rd_q    <= 1'b0;
      end else if (start) begin
        list_nvalid_q <= 1'b1;
        start_rd_q    <= 1'b0;
      end else if (list_copy) begin
        list_nvalid_q <= 1'b0;
        start_rd_q    <= 1'b1;
      end
    end
  end

  // Main engine, list engine and the shared memory sequencer
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      main_cur_addr_q <= `SGD_ZERO32;
      main_nxt_addr_q <= `SGD_ZERO32;
      main_cur_cnt_q  <= `SGD_ZERO32;
      main_nxt_cnt_q  <= `SGD_ZERO32;
      main_act_q      <= 1'b0;
      main_nfull_q    <= 1'b0;
      list_cur_addr_q <= `SGD_ZERO32;
      list_cur_len_q  <= `SGD_ZERO16;
      list_act_q      <= 1'b0;
      list_done_q     <= 1'b0;
      page_irq_q      <= 1'b0;
      state_q         <= ST_IDLE;
      entry_addr_q    <= `SGD_ZERO32;
      mem_req_q       <= 1'b0;
      mem_we_q        <= 1'b0;
      mem_addr_q      <= `SGD_ZERO32;
      mem_wdata_q     <= `SGD_ZERO32;
      mem_burst_q     <= 1'b0;
      brd_tx_data_q   <= `SGD_ZERO32;
      brd_tx_valid_q  <= 1'b0;
      brd_rx_ready_q  <= 1'b0;
    end else begin
      // Page interrupt clears only through its enable
      if (!en_page_q) begin
        page_irq_q <= 1'b0;
      end
      if (abort) begin
        // Abandon any bus cycle at once; the host sees the request drop
        main_act_q     <= 1'b0;
        main_nfull_q   <= 1'b0;
        list_act_q     <= 1'b0;
        list_done_q    <= 1'b0;
        state_q        <= ST_IDLE;
        mem_req_q      <= 1'b0;
        brd_tx_valid_q <= 1'b0;
        brd_rx_ready_q <= 1'b0;
      end else begin
        // List engine takes the next pair, or finishes once the length is used
        if (list_copy) begin
          list_cur_addr_q <= list_nxt_addr_q;
          list_cur_len_q  <= list_nxt_len_q;
          list_act_q      <= 1'b1;
          list_done_q     <= 1'b0;
        end else if (list_act_q && list_cur_len_q == `SGD_ZERO16 && !main_act_q
                     && !main_nfull_q && state_q == ST_IDLE) begin
          list_act_q  <= 1'b0;
          list_done_q <= 1'b1;
        end
        case (state_q)
          // Idle: move a word, close a page, load the next page or fetch an entry
          ST_IDLE: begin
            if (main_act_q && main_cur_cnt_q[15:0] != `SGD_ZERO16) begin
              mem_addr_q <= main_cur_addr_q;
              if (dir_rd_q) begin
                mem_req_q <= 1'b1;
                mem_we_q  <= 1'b0;
                state_q   <= ST_MRD;
              end else begin
                brd_rx_ready_q <= 1'b1;
                state_q        <= ST_RX;
              end
            end else if (main_act_q) begin
              // Page finished; current address stays one word step past the last word moved
              main_act_q <= 1'b0;
              if (en_page_q && main_cur_cnt_q[`SGD_B_ENTRY_PG]) begin
                page_irq_q <= 1'b1;
              end
            end else if (main_nfull_q) begin
              main_cur_addr_q <= main_nxt_addr_q;
              main_cur_cnt_q  <= main_nxt_cnt_q;
              main_nfull_q    <= 1'b0;
              main_act_q      <= 1'b1;
            end else if (list_act_q && !list_copy && list_cur_len_q != `SGD_ZERO16) begin
              mem_req_q  <= 1'b1;
              mem_we_q   <= 1'b0;
              mem_addr_q <= list_cur_addr_q;
              state_q    <= ST_LF0;
            end
          end
          // First entry word is the page address; request stays up for the second
          ST_LF0: begin
            if (mem_ack) begin
              entry_addr_q <= mem_rdata;
              mem_addr_q   <= list_cur_addr_q + `SGD_CTRL_WORD;
              state_q      <= ST_LF1;
            end
          end
          // Second word carries flags and count; the main next pair is now full
          ST_LF1: begin
            if (mem_ack) begin
              mem_req_q       <= 1'b0;
              main_nxt_addr_q <= entry_addr_q;
              main_nxt_cnt_q  <= mem_rdata;
              main_nfull_q    <= 1'b1;
              list_cur_addr_q <= list_cur_addr_q + `SGD_ENTRY_STEP;
              // A ragged tail shorter than one entry still ends the list
              if (list_cur_len_q > `SGD_ENTRY_BYTES) begin
                list_cur_len_q <= list_cur_len_q - `SGD_ENTRY_BYTES;
              end else begin
                list_cur_len_q <= `SGD_ZERO16;
              end
              state_q <= ST_IDLE;
            end
          end
          // Host read: park the word for the board
          ST_MRD: begin
            if (mem_ack) begin
              mem_req_q      <= 1'b0;
              brd_tx_data_q  <= mem_rdata;
              brd_tx_valid_q <= 1'b1;
              state_q        <= ST_TX;
            end
          end
          // Word leaves when the board takes it
          ST_TX: begin
            if (brd_tx_ready) begin
              brd_tx_valid_q  <= 1'b0;
              main_cur_addr_q <= main_addr_inc;
              main_cur_cnt_q  <= {main_cur_cnt_q[31:16], main_cnt_dec};
              state_q         <= ST_IDLE;
            end
          end
          // Board word becomes one host write
          ST_RX: begin
            if (brd_rx_valid) begin
              brd_rx_ready_q <= 1'b0;
              mem_req_q      <= 1'b1;
              mem_we_q       <= 1'b1;
              mem_wdata_q    <= brd_rx_data;
              // Burst lets the bus side coalesce; cleared means post each word
              mem_burst_q    <= burst_q;
              state_q        <= ST_MWR;
            end
          end
          // Host write accepted; step address and count
          ST_MWR: begin
            if (mem_ack) begin
              mem_req_q       <= 1'b0;
              mem_we_q        <= 1'b0;
              main_cur_addr_q <= main_addr_inc;
              main_cur_cnt_q  <= {main_cur_cnt_q[31:16], main_cnt_dec};
              state_q         <= ST_IDLE;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Main registers have no write path at all

endmodule // sgd_channel
`default_nettype wire

// ===== verification/sgd_host_mem.sv
`timescale 1ns/100ps
`default_nettype none
module sgd_host_mem (
  // Clock, reset and pacing
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        slow,
  // Beats from the channel
  input  wire logic        mem_req_q,
  input  wire logic        mem_we_q,
  input  wire logic [31:0] mem_addr_q,
  input  wire logic [31:0] mem_wdata_q,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack
);
  logic [31:0] words [0:255];
  logic [1:0]  wait_q;
  // Released bus shows the inverse so a stale read never matches
  assign mem_rdata = mem_ack ? words[mem_addr_q[9:2]] : ~words[mem_addr_q[9:2]];
  // Entries are laid out by the bench as address word, then flags and count
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      wait_q  <= 2'd0;
    end else if (mem_ack || !mem_req_q) begin
      if (mem_ack && mem_req_q && mem_we_q) words[mem_addr_q[9:2]] <= mem_wdata_q;
      mem_ack <= 1'b0;
      wait_q  <= 2'd0;
    end else if (!slow || wait_q == 2'd3) begin
      mem_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 2'd1;
    end
  end
endmodule // sgd_host_mem
`default_nettype wire

// ===== verification/sgd_channel_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sgd_channel_asserts (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_ack_q,
  // Host memory master
  input wire logic        mem_req_q,
  input wire logic        mem_we_q,
  input wire logic [31:0] mem_addr_q,
  input wire logic [31:0] mem_wdata_q,
  input wire logic [31:0] mem_rdata,
  input wire logic        mem_ack,
  // Board streams
  input wire logic [31:0] brd_tx_data_q,
  input wire logic        brd_tx_valid_q,
  input wire logic        brd_tx_ready,
  input wire logic [31:0] brd_rx_data,
  input wire logic        brd_rx_valid,
  input wire logic        brd_rx_ready_q,
  // Interrupts
  input wire logic        remote_irq,
  input wire logic        bus_irq_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic glb_q;
  logic rmt_q;
  logic abort_q;
  wire  abort_w = reg_wr && reg_addr == 8'h1c && reg_wdata[26];
  // Shadow of the enables; an abort may cut any beat short, so it is tracked too
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      glb_q   <= 1'b0;
      rmt_q   <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'hc4) begin
        glb_q <= reg_wdata[15];
        rmt_q <= reg_wdata[14];
      end
      abort_q <= abort_w;
    end
  end
  // Repetitions leave one cycle of slack for the enable register to land
  irq_gate_a: assert property (!glb_q [*3] |-> !bus_irq_q)
    else $error("bus interrupt while globally disabled");
  remote_irq_a: assert property ((glb_q && rmt_q && remote_irq) [*4] |-> bus_irq_q)
    else $error("enabled remote interrupt not passed on");
  reset_quiet_a: assert property ($rose(rst_b) |-> !bus_irq_q && !mem_req_q && !brd_tx_valid_q && !reg_ack_q)
    else $error("outputs active out of reset");
  beat_hold_a: assert property (mem_req_q && !mem_ack && !abort_w && !abort_q
    |=> mem_req_q && $stable(mem_addr_q) && $stable(mem_we_q))
    else $error("memory beat changed before accept");
  abort_stop_a: assert property (abort_w |-> ##[1:2] !mem_req_q)
    else $error("abort did not stop memory traffic");
  tx_source_a: assert property ($rose(brd_tx_valid_q)
    |-> $past(mem_req_q && mem_ack && !mem_we_q) && brd_tx_data_q == $past(mem_rdata))
    else $error("board word not from a host read");
  tx_hold_a: assert property (brd_tx_valid_q && !brd_tx_ready && !abort_w && !abort_q
    |=> brd_tx_valid_q && $stable(brd_tx_data_q))
    else $error("board word dropped before ready");
  rx_sink_a: assert property (brd_rx_valid && brd_rx_ready_q && !abort_w
    |=> mem_req_q && mem_we_q && mem_wdata_q == $past(brd_rx_data))
    else $error("board word not written to host");
  irq_level_a: assert property (bus_irq_q && !$past(reg_wr) && !$past(reg_wr, 2) && $past(remote_irq)
    |=> bus_irq_q)
    else $error("bus interrupt dropped without software action");
  ack_pulse_a: assert property ((reg_wr || reg_rd) |=> reg_ack_q)
    else $error("register access not acknowledged");
  cover property (bus_irq_q);
  cover property (brd_tx_valid_q && brd_tx_ready);
  cover property (mem_req_q && mem_ack && mem_we_q);
endmodule // sgd_channel_asserts
bind sgd_channel sgd_channel_asserts u_chk (.sys_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_ack_q,
  .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q, .mem_rdata, .mem_ack, .brd_tx_data_q, .brd_tx_valid_q,
  .brd_tx_ready, .brd_rx_data, .brd_rx_valid, .brd_rx_ready_q, .remote_irq, .bus_irq_q);
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // Design ports
  logic        sys_clk, rst_b, reg_wr, reg_rd, reg_ack_q, slow;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, mem_addr_q, mem_wdata_q, mem_rdata, brd_tx_data_q, brd_rx_data;
  logic        mem_req_q, mem_we_q, mem_burst_q, mem_ack, brd_tx_valid_q, brd_tx_ready, brd_rx_valid;
  logic        brd_rx_ready_q, remote_irq, bus_irq_q, hold_tx, rx_on;
  bit          burst_bad;
  // Bench state
  int          miscompares, checks_done, cycles, rx_n, i;
  logic [15:0] lfsr_q, rdy_s;
  logic [31:0] d;
  logic [31:0] txq[$], expq[$];
  sgd_channel dut (.sys_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q, .reg_ack_q,
    .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q, .mem_burst_q, .mem_rdata, .mem_ack, .brd_tx_data_q,
    .brd_tx_valid_q, .brd_tx_ready, .brd_rx_data, .brd_rx_valid, .brd_rx_ready_q, .remote_irq, .bus_irq_q);
  sgd_host_mem mem (.sys_clk, .rst_b, .slow, .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q, .mem_rdata,
    .mem_ack);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] rx_word(input int n);
    rx_word = {n[15:0], ~n[15:0]} ^ 32'h5a5a_0000;
  endfunction
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Board source: four words, inverted pattern once released
  assign brd_rx_valid = rx_on && rx_n < 4;
  assign brd_rx_data  = brd_rx_valid ? rx_word(rx_n) : ~rx_word(rx_n);
  // Board sink with random stalls, write monitor and hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (brd_tx_valid_q === 1'b1 && brd_tx_ready) txq.push_back(brd_tx_data_q);
    if (brd_rx_valid && brd_rx_ready_q === 1'b1) rx_n <= #1 rx_n + 1;
    if (mem_req_q && mem_ack && mem_we_q && mem_burst_q !== 1'b1) burst_bad <= 1'b1;
    rdy_s <= lfsr(rdy_s);
    brd_tx_ready <= #1 rdy_s[0] & ~hold_tx;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test;
    end
  end
  task automatic end_of_test;
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    #1 {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
    @(posedge sys_clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    #1 {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge sys_clk);
    #1 reg_rd = 1'b0;
    v = reg_rdata_q;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    checks_done++;
    if ((got & m) !== (exp & m)) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h mask %h", $time, got, exp, m);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd(a, d);
    chk(d, e, m);
  endtask
  // Bounded register poll for one bit
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(a, d);
      n++;
    end while (d[b] !== v && n < 3000);
    chk(d, {31'b0, v} << b, 32'h1 << b);
  endtask
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, rx_on, remote_irq, slow, hold_tx} = '0;
    {miscompares, checks_done} = '0;
    lfsr_q = 16'h0043;
    rdy_s  = 16'h0043;
    rst_b  = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    rdchk(8'h1c, 32'h20c0_0000, 32'hfcc7_0000);
    rdchk(8'hc8, 32'h0000_0000, 32'h0000_b000);
    rdchk(8'h90, 32'h0000_0000, 32'hffff_ffff);
    // Read-only places keep their value when written
    for (i = 0; i < 7; i++) if (i != 5) begin
      rd({i[5:0], 2'b00}, d);
      wr({i[5:0], 2'b00}, ~d);
      rdchk({i[5:0], 2'b00}, d, 32'hffff_ffff);
    end
    // Host to board, two pages, the first flagged
    wr(8'hc4, 32'h0000_8000);
    mem.words[64] = 32'h0000_0200;
    mem.words[65] = 32'h0001_0003;
    mem.words[66] = 32'h0000_0300;
    mem.words[67] = 32'h0000_0002;
    for (i = 0; i < 5; i++) begin
      d = {lfsr_q, lfsr(lfsr_q)};
      lfsr_q = lfsr(lfsr(lfsr_q));
      mem.words[i < 3 ? 128 + i : 189 + i] = d;
      expq.push_back(d);
    end
    wr(8'h14, 32'h0000_0100);
    wr(8'h1c, 32'h3a00_0010);
    poll(8'h1c, 30, 1'b1);
    for (i = 0; i < 300 && txq.size() < 5; i++) @(posedge sys_clk);
    chk(txq.size(), 5, 32'hffff_ffff);
    for (i = 0; i < 5; i++) chk(txq[i], expq[i], 32'hffff_ffff);
    rdchk(8'h1c, 32'h78c4_0000, 32'hfcc7_0000);
    rdchk(8'hc8, 32'h0000_9000, 32'h0000_b000);
    chk({31'b0, bus_irq_q}, 32'h1, 32'h1);
    // Current list address has walked one entry step past each of the two entries
    rdchk(8'h10, 32'h0000_0110, 32'hffff_ffff);
    wr(8'h1c, 32'h0000_0000);
    rdchk(8'h1c, 32'h6000_0000, 32'hf804_0000);
    rdchk(8'hc8, 32'h0000_0000, 32'h0000_b000);
    chk({31'b0, bus_irq_q}, 32'h0, 32'h1);
    // Board to host through a slow host, burst on, next-empty enable
    {slow, rx_on} = 2'b11;
    mem.words[96] = 32'h0000_0280;
    mem.words[97] = 32'h0000_0004;
    wr(8'h14, 32'h0000_0180);
    wr(8'h1c, 32'ha100_0008);
    poll(8'h1c, 29, 1'b1);
    rdchk(8'hc8, 32'h0000_9000, 32'h0000_b000);
    poll(8'h1c, 30, 1'b1);
    for (i = 0; i < 4; i++) chk(mem.words[160 + i], rx_word(i), 32'hffff_ffff);
    chk({31'b0, burst_bad}, 32'h0, 32'h1);
    // Abort while the board stalls
    {slow, hold_tx} = 2'b01;
    wr(8'h14, 32'h0000_0100);
    wr(8'h1c, 32'h2200_0010);
    repeat (20) @(posedge sys_clk);
    wr(8'h1c, 32'h0400_0000);
    rdchk(8'h1c, 32'h0000_0000, 32'h6400_0000);
    chk({31'b0, mem_req_q}, 32'h0, 32'h1);
    hold_tx = 1'b0;
    // Remote interrupt needs both enables
    remote_irq = 1'b1;
    wr(8'hc4, 32'h0000_4000);
    repeat (4) @(posedge sys_clk);
    #1 chk({31'b0, bus_irq_q}, 32'h0, 32'h1);
    rdchk(8'hc8, 32'h0000_2000, 32'h0000_a000);
    wr(8'hc4, 32'h0000_c000);
    repeat (4) @(posedge sys_clk);
    #1 chk({31'b0, bus_irq_q}, 32'h1, 32'h1);
    remote_irq = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 chk({31'b0, bus_irq_q}, 32'h0, 32'h1);
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
